// *** hw/nic_ctrl.sv ***
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "nic_regs.svh"

module nic_ctrl #(
    parameter logic [13:0] WAKE_MASK = `NIC_WAKE_MASK
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [9:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire nic_pkg::nic_cpu_s cpu_in,
    output nic_pkg::nic_irq_s      irq_out,
    input  wire logic [13:0]       periph_req,
    input  wire logic              top_level_irq,
    input  wire logic [11:0]       ext_pin
);

    localparam logic [11:0] GRP_A     = `NIC_GRP_A;
    localparam logic [11:0] GRP_B     = `NIC_GRP_B;
    localparam logic [11:0] RISE_PINS = `NIC_RISE_PINS;

    logic [7:0]  en_low_r;
    logic [7:0]  sense_r;
    logic [7:0]  prio_r [0:3];
    logic [1:0]  cond_prio_r;
    logic        trap_pend_r;
    logic        top_pend_r;
    logic        grp_a_r;
    logic        grp_b_r;
    logic        nand_a_prev_r;
    logic        nand_b_prev_r;
    logic [11:0] pin_prev_r;
    logic        irq_req_r;
    logic        irq_wake_r;
    logic [3:0]  irq_vec_r;
    logic [31:0] prdata_r;

    logic [31:0] prio_flat;
    logic [7:0]  idx;
    logic        acc;
    logic        wr;
    logic        take_now;
    logic [11:0] en_pin;
    logic [11:0] norm;
    logic [11:0] both_ev;
    logic [11:0] lvl_low;
    logic        nand_a;
    logic        nand_b;
    logic        edge_a;
    logic        edge_b;
    logic        level_a;
    logic        level_b;
    logic [13:0] pend;
    logic        arb_found;
    logic [3:0]  arb_vec;
    logic [1:0]  best_l;
    logic [1:0]  vec_field;
    logic        vec_nmi;
    logic [31:0] rd_mux;

    function automatic logic [1:0] lvl(input logic [1:0] b);
        case (b)
            2'b10:   lvl = 2'd0;
            2'b01:   lvl = 2'd1;
            2'b00:   lvl = 2'd2;
            default: lvl = 2'd3;
        endcase
    endfunction

    function automatic logic prio_hit(input logic [7:0] i);
        prio_hit = (i >= `NIC_IDX_PRIO0) && (i <= `NIC_IDX_PRIO3);
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        mapped = prio_hit(i) || i == `NIC_IDX_EN_LOW || i == `NIC_IDX_SENSE_HIGH
              || i == `NIC_IDX_COND_PRIO || i == `NIC_IDX_STATUS;
    endfunction

    function automatic logic [7:0] prio_merge(input logic [7:0] old,
                                              input logic [7:0] wd,
                                              input logic       ro_top);
        logic [7:0] res;
        res = old;
        for (int k = 0; k < 4; k++) begin
            if (wd[2*k +: 2] != `NIC_PAT_LVL0) begin
                res[2*k +: 2] = wd[2*k +: 2];
            end
        end
        if (ro_top) begin
            res = res | `NIC_PRIO3_RO;
        end
        prio_merge = res;
    endfunction

    // APB: read data latched in setup, zero wait states
    assign idx      = paddr[9:2];
    assign acc      = psel & penable;
    assign wr       = acc & pwrite & mapped(idx);
    assign pready   = 1'b1;
    assign pslverr  = acc & ~mapped(idx);
    assign prdata   = prdata_r;
    assign take_now = cpu_in.take & irq_req_r;

    assign prio_flat = {prio_r[3], prio_r[2], prio_r[1], prio_r[0]};
    assign vec_field = prio_flat[{irq_vec_r, 1'b0} +: 2];
    assign vec_nmi   = (irq_vec_r == `NIC_VEC_TRAP) || (irq_vec_r == `NIC_VEC_TOP);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `NIC_IDX_EN_LOW:     rd_mux[7:0] = en_low_r;
            `NIC_IDX_PRIO0:      rd_mux[7:0] = prio_r[0];
            `NIC_IDX_PRIO1:      rd_mux[7:0] = prio_r[1];
            `NIC_IDX_PRIO2:      rd_mux[7:0] = prio_r[2];
            `NIC_IDX_PRIO3:      rd_mux[7:0] = prio_r[3];
            `NIC_IDX_SENSE_HIGH: rd_mux[7:0] = sense_r;
            `NIC_IDX_COND_PRIO: begin
                rd_mux[`NIC_COND_HI_POS] = cond_prio_r[1];
                rd_mux[`NIC_COND_LO_POS] = cond_prio_r[0];
            end
            `NIC_IDX_STATUS:     rd_mux[7:0] = {irq_req_r, irq_wake_r, grp_a_r, grp_b_r,
                                                irq_vec_r};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_low_r <= `NIC_RST_EN;
            sense_r  <= `NIC_RST_EN;
        end else if (wr && idx == `NIC_IDX_EN_LOW) begin
            en_low_r <= pwdata[7:0];
        end else if (wr && idx == `NIC_IDX_SENSE_HIGH) begin
            sense_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < 4; r++) begin
                prio_r[r] <= `NIC_RST_PRIO;
            end
        end else if (wr && prio_hit(idx)) begin
            prio_r[idx[1:0] + 2'd2] <= prio_merge(prio_r[idx[1:0] + 2'd2], pwdata[7:0],
                                                 idx == `NIC_IDX_PRIO3);
        end
    end

    // entry outranks instructions; bus write stands for a direct register load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_prio_r <= `NIC_RST_COND;
        end else if (take_now) begin
            cond_prio_r <= vec_nmi ? `NIC_PAT_LVL3 : vec_field;
        end else if (wr && idx == `NIC_IDX_COND_PRIO) begin
            cond_prio_r <= {pwdata[`NIC_COND_HI_POS], pwdata[`NIC_COND_LO_POS]};
        end else if (cpu_in.irq_disable_instr) begin
            cond_prio_r <= `NIC_PAT_LVL3;
        end else if (cpu_in.irq_enable_instr || cpu_in.halt_instr
                     || cpu_in.wait_for_irq_instr) begin
            cond_prio_r <= `NIC_PAT_LVL0;
        end else if (cpu_in.irq_return_instr || cpu_in.pop_cc) begin
            cond_prio_r <= cpu_in.restore;
        end
    end

    // per-pin sensitivity and normalisation
    assign en_pin = {sense_r[3:0], en_low_r};

    generate
        for (genvar i = 0; i < 12; i++) begin : g_pin
            nic_pkg::nic_sense_e m;
            always_comb begin
                if (i >= 10) begin
                    m = nic_pkg::nic_sense_e'(sense_r[`NIC_SENSE_UP_POS +: 2]);
                end else if (i >= 8) begin
                    m = nic_pkg::nic_sense_e'(sense_r[`NIC_SENSE_LO_POS +: 2]);
                end else if (RISE_PINS[i]) begin
                    m = nic_pkg::NIC_SENSE_RISE;
                end else begin
                    m = nic_pkg::NIC_SENSE_FALL;
                end
            end
            assign norm[i]    = (m == nic_pkg::NIC_SENSE_RISE) ? ~ext_pin[i] : ext_pin[i];
            assign both_ev[i] = en_pin[i] & (m == nic_pkg::NIC_SENSE_BOTH)
                              & (ext_pin[i] ^ pin_prev_r[i]);
            assign lvl_low[i] = en_pin[i] & (m == nic_pkg::NIC_SENSE_FALL_LOW) & ~ext_pin[i];
        end
    endgenerate

    // one active pin masks the other pins' edges, as the shared line is a NAND; both-edge and low-level pins bypass it
    assign nand_a  = ~&(norm | ~(en_pin & GRP_A));
    assign nand_b  = ~&(norm | ~(en_pin & GRP_B));
    assign edge_a  = (nand_a & ~nand_a_prev_r) | (|(both_ev & GRP_A));
    assign edge_b  = (nand_b & ~nand_b_prev_r) | (|(both_ev & GRP_B));
    assign level_a = |(lvl_low & GRP_A);
    assign level_b = |(lvl_low & GRP_B);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_r    <= 12'hFFF;
            nand_a_prev_r <= 1'b1;
            nand_b_prev_r <= 1'b1;
        end else begin
            pin_prev_r    <= ext_pin;
            nand_a_prev_r <= nand_a;
            nand_b_prev_r <= nand_b;
        end
    end

    // set wins over the clear on entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_a_r <= 1'b0;
            grp_b_r <= 1'b0;
        end else begin
            if (edge_a) begin
                grp_a_r <= 1'b1;
            end else if (take_now && irq_vec_r == `NIC_VEC_PA) begin
                grp_a_r <= 1'b0;
            end
            if (edge_b) begin
                grp_b_r <= 1'b1;
            end else if (take_now && irq_vec_r == `NIC_VEC_PB) begin
                grp_b_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_pend_r <= 1'b0;
            top_pend_r  <= 1'b0;
        end else begin
            if (cpu_in.trap_instr) begin
                trap_pend_r <= 1'b1;
            end else if (take_now && irq_vec_r == `NIC_VEC_TRAP) begin
                trap_pend_r <= 1'b0;
            end
            if (top_level_irq) begin
                top_pend_r <= 1'b1;
            end else if (take_now && irq_vec_r == `NIC_VEC_TOP) begin
                top_pend_r <= 1'b0;
            end
        end
    end

    always_comb begin
        pend    = periph_req;
        pend[0] = 1'b0;
        pend[2] = grp_a_r | level_a;
        pend[3] = grp_b_r | level_b;
    end

    // a field raised while its vector runs competes at once, so it re-enters
    always_comb begin
        arb_found = 1'b0;
        arb_vec   = `NIC_VEC_TOP;
        best_l    = 2'd0;
        for (int v = 13; v >= 1; v--) begin
            if (pend[v] && (!cpu_in.in_halt || WAKE_MASK[v])
                && lvl(prio_flat[2*v +: 2]) > lvl(cond_prio_r)
                && (!arb_found || lvl(prio_flat[2*v +: 2]) >= best_l)) begin
                arb_found = 1'b1;
                arb_vec   = 4'(v);
                best_l    = lvl(prio_flat[2*v +: 2]);
            end
        end
        if (!cpu_in.in_halt && trap_pend_r) begin
            arb_found = 1'b1;
            arb_vec   = `NIC_VEC_TRAP;
        end else if (!cpu_in.in_halt && top_pend_r) begin
            arb_found = 1'b1;
            arb_vec   = `NIC_VEC_TOP;
        end
    end

    // request drops for the cycle after entry while latches settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req_r  <= 1'b0;
            irq_vec_r  <= `NIC_VEC_TOP;
            irq_wake_r <= 1'b0;
        end else begin
            irq_req_r  <= arb_found & ~take_now;
            irq_vec_r  <= arb_vec;
            irq_wake_r <= cpu_in.in_halt & (|(pend & WAKE_MASK));
        end
    end

    assign irq_out = '{req: irq_req_r, vec: irq_vec_r, wake: irq_wake_r, prio: cond_prio_r};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_prio3_top_ones: assert property (prio_r[3][7:4] == 4'hF)
        else $error("fourth priority register top nibble not ones");
    a_lvl0_write_kept: assert property (
        (wr && idx == `NIC_IDX_PRIO0 && pwdata[1:0] == `NIC_PAT_LVL0)
        |=> prio_r[0][1:0] == $past(prio_r[0][1:0]))
        else $error("level-0 pattern overwrote a field");
    a_take_loads_field: assert property (
        (take_now && !vec_nmi) |=> cond_prio_r == $past(vec_field))
        else $error("entry did not load vector priority");
    a_nmi_sets_ones: assert property ((take_now && vec_nmi) |=> cond_prio_r == 2'b11)
        else $error("non-maskable entry did not set level 3");
    a_trap_at_lvl3: assert property (
        (trap_pend_r && !cpu_in.in_halt && !take_now && cond_prio_r == 2'b11)
        |=> irq_req_r && irq_vec_r == `NIC_VEC_TRAP)
        else $error("trap not requested at level 3");
    a_mask_beats_cur: assert property (
        (irq_req_r && !vec_nmi && !$past(take_now))
        |-> lvl($past(prio_flat[{arb_vec, 1'b0} +: 2])) > lvl($past(cond_prio_r)))
        else $error("maskable request below current level");
    a_grp_clear_take: assert property (
        (take_now && irq_vec_r == `NIC_VEC_PA && !edge_a) |=> !grp_a_r)
        else $error("edge latch not cleared on entry");
    a_halt_wake_only: assert property (
        (irq_req_r && $past(cpu_in.in_halt)) |-> WAKE_MASK[irq_vec_r])
        else $error("non-waking vector served first out of halt");
    a_disable_instr: assert property (
        (cpu_in.irq_disable_instr && !take_now && !wr) |=> cond_prio_r == 2'b11)
        else $error("disable instruction did not set level 3");

    c_mask_take: cover property (take_now && !vec_nmi);
    c_trap_take: cover property (take_now && irq_vec_r == `NIC_VEC_TRAP);
    c_level_retake: cover property (level_b ##1 take_now ##[1:20] irq_req_r);
    c_halt_wake: cover property (irq_wake_r);

endmodule // nic_ctrl

// *** hw/nic_pkg.sv ***
package nic_pkg;

    typedef enum logic [1:0] {
        NIC_SENSE_FALL_LOW = 2'b00,
        NIC_SENSE_RISE     = 2'b01,
        NIC_SENSE_FALL     = 2'b10,
        NIC_SENSE_BOTH     = 2'b11
    } nic_sense_e;

    typedef struct packed {
        logic       take;
        logic       irq_enable_instr;
        logic       irq_disable_instr;
        logic       halt_instr;
        logic       wait_for_irq_instr;
        logic       irq_return_instr;
        logic       pop_cc;
        logic       trap_instr;
        logic       in_halt;
        logic [1:0] restore;
    } nic_cpu_s;

    typedef struct packed {
        logic       req;
        logic [3:0] vec;
        logic       wake;
        logic [1:0] prio;
    } nic_irq_s;

endpackage

// *** hw/nic_regs.svh ***
`ifndef NIC_REGS_SVH
`define NIC_REGS_SVH

// register indexes; byte address is four times the index
`define NIC_IDX_EN_LOW     8'h08
`define NIC_IDX_PRIO0      8'h32
`define NIC_IDX_PRIO1      8'h33
`define NIC_IDX_PRIO2      8'h34
`define NIC_IDX_PRIO3      8'h35
`define NIC_IDX_SENSE_HIGH 8'h39
`define NIC_IDX_COND_PRIO  8'h40
`define NIC_IDX_STATUS     8'h41

`define NIC_RST_EN         8'h00
`define NIC_RST_PRIO       8'hFF
`define NIC_RST_COND       2'h3
`define NIC_PRIO3_RO       8'hF0

`define NIC_PAT_LVL0       2'h2
`define NIC_PAT_LVL3       2'h3

`define NIC_COND_HI_POS    5
`define NIC_COND_LO_POS    3
`define NIC_SENSE_UP_POS   6
`define NIC_SENSE_LO_POS   4

`define NIC_VEC_TOP        4'h0
`define NIC_VEC_PA         4'h2
`define NIC_VEC_PB         4'h3
`define NIC_VEC_TRAP       4'hE
`define NIC_WAKE_MASK      14'h000E
`define NIC_GRP_A          12'h00F
`define NIC_GRP_B          12'hFF0
`define NIC_RISE_PINS      12'h030

`endif

// *** sim/nested_irq_priority_ctrl_tb.sv ***
`timescale 1ns/1ns
`include "nic_regs.svh"

module nested_irq_priority_ctrl_tb;
    localparam int EN = 9, DIS = 8, RET = 5, POP = 4, TRAP = 3;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              top_level_irq, take_en;
    logic [9:0]        paddr;
    logic [31:0]       pwdata, prdata;
    logic [13:0]       periph_req;
    logic [11:0]       ext_pin;
    logic [3:0]        take_delay, taken_vec;
    logic [7:0]        taken_cnt;
    nic_pkg::nic_cpu_s cpu_in, instr;
    nic_pkg::nic_irq_s irq;
    int                mismatches, cmp_count, takes;

    nic_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_in(cpu_in), .irq_out(irq), .periph_req(periph_req),
        .top_level_irq(top_level_irq), .ext_pin(ext_pin));
    nic_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq(irq), .take_en(take_en),
        .take_delay(take_delay), .instr(instr), .cpu_out(cpu_in), .taken_vec(taken_vec),
        .taken_cnt(taken_cnt));

    always #5 pclk = ~pclk;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait on a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, i, d, r, e);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] x, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, i, 8'h00, r, e);
        chk(what, r, {24'h000000, x});
    endtask

    task automatic pulse(input int b, input logic [1:0] rs);
        instr[b]      <= 1'b1;
        instr.restore <= rs;
        @(posedge pclk);
        instr[b] <= 1'b0;
        @(posedge pclk);
    endtask

    // takes are counted in the CPU model, so a take during a pulse is not missed
    task automatic wait_take(input logic [3:0] v, input logic [1:0] p);
        int n;
        takes++;
        n = 0;
        while (taken_cnt !== 8'(takes) && n < 60) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        chk("take count", 32'(taken_cnt), 32'(8'(takes)));
        chk("taken vector", 32'(taken_vec), 32'(v));
        chk("entry priority", 32'(irq.prio), 32'(p));
    endtask

    task automatic no_take(input int n);
        repeat (n) @(posedge pclk);
        chk("no take", 32'(taken_cnt), 32'(8'(takes)));
    endtask

    function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] w, input bit t);
        merge = o;
        for (int f = 0; f < 4; f++)
            if (w[2*f+:2] != 2'b10) merge[2*f+:2] = w[2*f+:2];
        if (t) merge[7:4] = 4'hF;
    endfunction

    initial begin
        #300000;
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  ep [4];
        logic [7:0]  d;
        int          k;
        {pclk, psel, penable, pwrite, top_level_irq, presetn} = 6'h00;
        {paddr, pwdata, periph_req, take_delay} = '0;
        instr = '0;
        take_en = 1'b1;
        ext_pin = 12'hFFF;
        {mismatches, cmp_count, takes} = '0;
        void'($urandom(32'h44D6));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`NIC_IDX_EN_LOW, 8'h00, "enable low reset");
        rd(`NIC_IDX_SENSE_HIGH, 8'h00, "sense reset");
        rd(`NIC_IDX_COND_PRIO, 8'h28, "current priority reset");
        for (k = 0; k < 4; k++) begin
            rd(`NIC_IDX_PRIO0 + 8'(k), 8'hFF, "priority reset");
            ep[k] = 8'hFF;
        end
        apb(1'b0, 8'h10, 8'h00, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        // no rising-edge pin here: enabling one while its pin idles high latches a request
        wr(`NIC_IDX_EN_LOW, 8'h8B);
        rd(`NIC_IDX_EN_LOW, 8'h8B, "enable low rw");
        for (int n = 0; n < 16; n++) begin
            k = $urandom_range(3);
            d = 8'($urandom);
            wr(`NIC_IDX_PRIO0 + 8'(k), d);
            ep[k] = merge(ep[k], d, k == 3);
            rd(`NIC_IDX_PRIO0 + 8'(k), ep[k], "priority field");
        end
        wr(`NIC_IDX_EN_LOW, 8'h00);
        wr(`NIC_IDX_COND_PRIO, 8'h08);
        rd(`NIC_IDX_COND_PRIO, 8'h08, "current priority rw");
        chk("level 1 pair", 32'(irq.prio), 32'h1);
        pulse(DIS, 2'b00);
        chk("disable", 32'(irq.prio), 32'h3);
        pulse(EN, 2'b00);
        chk("enable", 32'(irq.prio), 32'h2);
        pulse(RET, 2'b00);
        chk("return", 32'(irq.prio), 32'h0);
        pulse(POP, 2'b10);
        chk("pop", 32'(irq.prio), 32'h2);
        wr(`NIC_IDX_PRIO0, 8'h15);
        wr(`NIC_IDX_PRIO1, 8'hF3);
        take_en <= 1'b0;
        periph_req <= 14'h0022;
        repeat (4) @(posedge pclk);
        chk("request", 32'(irq.req), 32'h1);
        chk("winner", 32'(irq.vec), 32'h5);
        take_en <= 1'b1;
        wait_take(4'h5, 2'b00);
        no_take(6);
        wr(`NIC_IDX_PRIO1, 8'hFF);
        wait_take(4'h5, 2'b11);
        periph_req <= 14'h0002;
        repeat (3) @(posedge pclk);
        pulse(RET, 2'b10);
        wait_take(4'h1, 2'b01);
        periph_req <= 14'h0000;
        take_delay <= 4'h2;
        pulse(DIS, 2'b00);
        top_level_irq <= 1'b1;
        @(posedge pclk);
        top_level_irq <= 1'b0;
        wait_take(`NIC_VEC_TOP, 2'b11);
        pulse(TRAP, 2'b00);
        wait_take(`NIC_VEC_TRAP, 2'b11);
        take_delay <= 4'h0;
        wr(`NIC_IDX_EN_LOW, 8'h01);
        pulse(EN, 2'b00);
        ext_pin[0] <= 1'b0;
        wait_take(`NIC_VEC_PA, 2'b01);
        ext_pin[0] <= 1'b1;
        pulse(RET, 2'b10);
        no_take(6);
        ext_pin[4] <= 1'b0;
        wr(`NIC_IDX_EN_LOW, 8'h10);
        ext_pin[4] <= 1'b1;
        wait_take(`NIC_VEC_PB, 2'b00);
        wr(`NIC_IDX_EN_LOW, 8'h00);
        pulse(RET, 2'b10);
        ext_pin[11] <= 1'b0;
        wr(`NIC_IDX_SENSE_HIGH, 8'h48);
        ext_pin[11] <= 1'b1;
        wait_take(`NIC_VEC_PB, 2'b00);
        pulse(RET, 2'b10);
        ext_pin[11] <= 1'b0;
        no_take(6);
        wr(`NIC_IDX_SENSE_HIGH, 8'h21);
        ext_pin <= 12'hEFF;
        wait_take(`NIC_VEC_PB, 2'b00);
        pulse(RET, 2'b10);
        ext_pin[8] <= 1'b1;
        wr(`NIC_IDX_SENSE_HIGH, 8'h04);
        ext_pin[10] <= 1'b0;
        wait_take(`NIC_VEC_PB, 2'b00);
        pulse(RET, 2'b10);
        wait_take(`NIC_VEC_PB, 2'b00);
        ext_pin[10] <= 1'b1;
        pulse(RET, 2'b10);
        no_take(6);
        wr(`NIC_IDX_SENSE_HIGH, 8'h00);
        instr.in_halt <= 1'b1;
        wr(`NIC_IDX_PRIO1, 8'hF3);
        periph_req <= 14'h0020;
        no_take(6);
        chk("no wake", 32'(irq.wake), 32'h0);
        take_en <= 1'b0;
        periph_req <= 14'h0022;
        repeat (4) @(posedge pclk);
        chk("wake", 32'(irq.wake), 32'h1);
        take_en <= 1'b1;
        wait_take(4'h1, 2'b01);
        periph_req <= 14'h0020;
        instr.in_halt <= 1'b0;
        wait_take(4'h5, 2'b00);
        periph_req <= 14'h0000;
        give_verdict();
    end
endmodule // nested_irq_priority_ctrl_tb

// *** sim/nic_cpu_model.sv ***
`timescale 1ns/1ns

// core side: takes a request after a programmable delay, passes instructions
module nic_cpu_model (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire nic_pkg::nic_irq_s irq,
    input  wire logic              take_en,
    input  wire logic [3:0]        take_delay,
    input  wire nic_pkg::nic_cpu_s instr,
    output nic_pkg::nic_cpu_s      cpu_out,
    output logic [3:0]             taken_vec,
    output logic [7:0]             taken_cnt
);
    logic [3:0] wait_r;
    logic       take_r;

    // take only while req is still high, so the pulse is ignored only if req falls at the edge that raises it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_r    <= 1'b0;
            wait_r    <= 4'h0;
            taken_vec <= 4'h0;
            taken_cnt <= 8'h00;
        end else if (take_r) begin
            take_r <= 1'b0;
        end else if (take_en && irq.req) begin
            if (wait_r >= take_delay) begin
                take_r    <= 1'b1;
                wait_r    <= 4'h0;
                taken_vec <= irq.vec;
                taken_cnt <= taken_cnt + 8'h01;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end else begin
            wait_r <= 4'h0;
        end
    end

    always_comb begin
        cpu_out      = instr;
        cpu_out.take = take_r;
    end
endmodule // nic_cpu_model
